// ---- inc/embi_pkg.sv ----
/*
  Constants, enumerations and carrier structs of the external memory bus
  interface: bus widths, memory width codes, strobe spaces and states.
  Assumes a single clock domain; every file imports the whole package.
*/
// How it works
// - The 32-bit data bus is two-way and floats when not driven.
// - The 24-bit address bus is an output that can float.
// - The direction line is high for reads and low for writes.
// - Lane 3 strobe is a byte enable on 32-bit memory, address one else.
// - Lane 2 strobe is a byte enable on 32-bit memory, address two on 8-bit.
// - Lanes 1 and 0 are byte enables on 32- and 16-bit memory; on 8-bit only lane 0 is.
// - Peripheral accesses use their own strobe on the shared bus lines.
// - The outside device signals ready and the access ends only then.
// - A low release request finishes the access and floats the bus.
// - While released nothing starts; resume on request high or inhibit.
// - The grant goes low only once the bus floats and access is held.
// - The grant is high when the request is high or inhibit is set.
// - With width select low an instruction is one 32-bit fetch.
// - With width select high an instruction is two 16-bit fetches.
// - Width select at reset sets both strobe groups' width values.
// - High-impedance, release and reset float bus lines; strobes, grant less.
`default_nettype none
package embi_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [1:0] SUB_FIRST  = 2'h0;
  localparam logic [1:0] SUB_SECOND = 2'h2;

  typedef enum logic [1:0] {
    WID_8  = 2'b00,
    WID_16 = 2'b01,
    WID_32 = 2'b10
  } embi_width_e;

  typedef enum logic [1:0] {
    SPC_STRB0 = 2'b00,
    SPC_STRB1 = 2'b01,
    SPC_IO    = 2'b10
  } embi_space_e;

  typedef enum logic [1:0] {
    ST_INIT     = 2'b00,
    ST_IDLE     = 2'b01,
    ST_ACCESS   = 2'b10,
    ST_RELEASED = 2'b11
  } embi_state_e;

  // One memory strobe group; lanes 3 and 2 are active low when enables.
  typedef struct packed {
    logic lane3OrAddr1;
    logic lane2OrAddr2;
    logic lane1N;
    logic lane0N;
  } embi_strobe_s;

  typedef struct packed {
    logic              write;
    logic              fetch;
    embi_space_e       space;
    logic [1:0]        sub;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } embi_req_s;

  typedef struct packed {
    embi_width_e widthZero;
    embi_width_e widthOne;
  } embi_cfg_s;

  localparam embi_strobe_s STRB_IDLE = 4'hf;
endpackage
`default_nettype wire

// ---- hdl/embi_bus_if.sv ----
/*
  External memory bus interface, device side: turns core requests into
  pin-level accesses on two memory strobe groups and one peripheral strobe,
  handles ready, bus release and the program fetch width.
  Assumes pins are synchronous to clk_sys; tri-state is resolved outside.
*/
`timescale 1ns/100ps
`default_nettype none
module embi_bus_if (
  // Clock and reset.
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Core request and answer.
  input  wire logic                      reqValid,
  output logic                           reqReady,
  input  wire embi_pkg::embi_req_s       req,
  output logic                           respValid,
  output logic [embi_pkg::DATA_W-1:0]    respData,
  // Core width configuration and release inhibit.
  input  wire logic                      cfgWrite,
  input  wire embi_pkg::embi_cfg_s       cfgIn,
  output embi_pkg::embi_cfg_s            cfgOut,
  input  wire logic                      releaseInhibitBit,
  // External bus pins.
  output logic [embi_pkg::ADDR_W-1:0]    extAddr,
  output logic                           extAddrOe,
  output logic [embi_pkg::DATA_W-1:0]    extDataOut,
  input  wire logic [embi_pkg::DATA_W-1:0] extDataIn,
  output logic                           extDataOe,
  output logic                           readNotWrite,
  output logic                           readNotWriteOe,
  output embi_pkg::embi_strobe_s         memStrobeZero,
  output embi_pkg::embi_strobe_s         memStrobeOne,
  output logic                           peripheralIoStrobeN,
  output logic                           strobeOe,
  input  wire logic                      readyN,
  input  wire logic                      busReleaseReqN,
  output logic                           busReleaseGrantN,
  output logic                           busReleaseGrantOe,
  input  wire logic                      programWidthSelect,
  input  wire logic                      forceHighImpedance
);
  import embi_pkg::*;

  typedef struct packed {
    embi_state_e       st;
    embi_cfg_s         cfg;
    logic              write;
    logic              fetch;
    logic              twoHalf;
    embi_space_e       space;
    logic [1:0]        sub;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              done;
  } embi_st_s;

  embi_st_s cur_ff;
  embi_st_s nxt_cur;
  logic     wantRelease;
  embi_width_e accWidth;
  embi_strobe_s laneGroup;

  ////////////////////////////////////////////////////////////////////////
  // Lane strobes from the effective width and the byte offset.
  function automatic embi_strobe_s lanes(embi_width_e w, logic [1:0] s,
                                         logic act);
    embi_strobe_s r;
    r = STRB_IDLE;
    case (w)
      WID_32: begin
        r = act ? 4'h0 : 4'hf;
      end
      WID_16: begin
        r.lane3OrAddr1 = s[1];
        r.lane1N = ~act;
        r.lane0N = ~act;
      end
      WID_8: begin
        r.lane3OrAddr1 = s[0];
        r.lane2OrAddr2 = s[1];
        r.lane0N = ~act;
      end
      default: r = STRB_IDLE;
    endcase
    return r;
  endfunction

  // A request for release is honoured only when inhibit is clear.
  assign wantRelease = ~busReleaseReqN & ~releaseInhibitBit;
  // Fetch width follows the select pin as latched when the fetch is taken; data follows its group.
  always_comb begin
    if (cur_ff.twoHalf) begin
      accWidth = WID_16;
    end else if (cur_ff.fetch) begin
      // A single fetch is always a full word, whatever the group width.
      accWidth = WID_32;
    end else if (cur_ff.space == SPC_STRB1) begin
      accWidth = cur_ff.cfg.widthOne;
    end else if (cur_ff.space == SPC_STRB0) begin
      accWidth = cur_ff.cfg.widthZero;
    end else begin
      accWidth = WID_32;
    end
  end
  assign laneGroup = lanes(accWidth, cur_ff.sub, cur_ff.st == ST_ACCESS);

  ////////////////////////////////////////////////////////////////////////
  // Next state. Release is checked only between accesses, so an access in
  // flight always finishes before the bus floats.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    if (cfgWrite && cur_ff.st != ST_INIT) begin
      nxt_cur.cfg = cfgIn;
    end
    case (cur_ff.st)
      ST_INIT: begin
        // Width select caught on the first edge after reset release.
        nxt_cur.cfg.widthZero = programWidthSelect ? WID_16 : WID_32;
        nxt_cur.cfg.widthOne  = programWidthSelect ? WID_16 : WID_32;
        nxt_cur.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (wantRelease) begin
          nxt_cur.st = ST_RELEASED;
        end else if (reqValid) begin
          nxt_cur.st      = ST_ACCESS;
          nxt_cur.write   = req.write & ~req.fetch;
          nxt_cur.fetch   = req.fetch;
          nxt_cur.twoHalf = req.fetch & programWidthSelect;
          nxt_cur.space   = req.space;
          nxt_cur.sub     = req.fetch ? SUB_FIRST : req.sub;
          nxt_cur.addr    = req.addr;
          nxt_cur.data    = req.data;
        end
      end
      ST_ACCESS: begin
        if (!readyN) begin
          if (cur_ff.twoHalf && cur_ff.sub == SUB_FIRST) begin
            nxt_cur.data[HALF_W-1:0] = extDataIn[HALF_W-1:0];
            nxt_cur.sub = SUB_SECOND;
          end else begin
            nxt_cur.st   = ST_IDLE;
            nxt_cur.done = 1'b1;
            if (cur_ff.twoHalf) begin
              nxt_cur.data[DATA_W-1:HALF_W] = extDataIn[HALF_W-1:0];
            end else if (!cur_ff.write) begin
              case (accWidth)
                WID_16: nxt_cur.data = {{HALF_W{1'b0}},
                                        extDataIn[HALF_W-1:0]};
                WID_8: nxt_cur.data = {{(DATA_W-BYTE_W){1'b0}},
                                       extDataIn[BYTE_W-1:0]};
                default: nxt_cur.data = extDataIn;
              endcase
            end
          end
        end
      end
      ST_RELEASED: begin
        if (!wantRelease) begin
          nxt_cur.st = ST_IDLE;
        end
      end
      default: nxt_cur.st = ST_IDLE;
    endcase
  end

  // State register; reset holds the bus idle with widths at 32 bits.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{st: ST_INIT, cfg: '{WID_32, WID_32}, space: SPC_STRB0,
                  default: '0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core side.
  assign reqReady  = (cur_ff.st == ST_IDLE) & ~wantRelease;
  assign respValid = cur_ff.done;
  assign respData  = cur_ff.data;
  assign cfgOut    = cur_ff.cfg;

  // Pin side. Address, data and direction float on high impedance, release
  // or reset;
  // strobes keep driving high under reset so memories stay deselected.
  assign extAddr        = cur_ff.addr;
  assign extDataOut     = cur_ff.data;
  assign readNotWrite   = ~cur_ff.write;
  assign extAddrOe      = rst_n & ~forceHighImpedance
                          & (cur_ff.st != ST_RELEASED);
  assign readNotWriteOe = extAddrOe;
  assign extDataOe      = extAddrOe & cur_ff.write
                          & (cur_ff.st == ST_ACCESS);
  assign strobeOe       = ~forceHighImpedance
                          & (cur_ff.st != ST_RELEASED);
  assign memStrobeZero  = (cur_ff.space == SPC_STRB0) ? laneGroup
                          : STRB_IDLE;
  assign memStrobeOne   = (cur_ff.space == SPC_STRB1) ? laneGroup
                          : STRB_IDLE;
  assign peripheralIoStrobeN = ~((cur_ff.space == SPC_IO)
                                 & (cur_ff.st == ST_ACCESS));
  assign busReleaseGrantN  = cur_ff.st != ST_RELEASED;
  assign busReleaseGrantOe = ~forceHighImpedance;

  ////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic inAcc;
  assign inAcc = cur_ff.st == ST_ACCESS;

  grant_floats_a: assert property (
    !busReleaseGrantN |-> !extAddrOe && !extDataOe && !readNotWriteOe
    && !strobeOe && !inAcc) else $error("grant low with bus driven");
  grant_high_a: assert property (
    busReleaseReqN || releaseInhibitBit |=> busReleaseGrantN)
    else $error("grant low without request");
  release_idle_a: assert property (
    inAcc && !readyN && !cur_ff.twoHalf && wantRelease
    |=> !inAcc ##1 !busReleaseGrantN)
    else $error("release after access not taken");
  no_start_a: assert property (
    wantRelease && !inAcc |-> !reqReady ##1 !inAcc)
    else $error("access started while released");
  ready_hold_a: assert property (
    inAcc && readyN |=> inAcc && $stable(extAddr)
    && $stable(memStrobeZero) && $stable(memStrobeOne)
    && $stable(peripheralIoStrobeN) && $stable(readNotWrite))
    else $error("access moved without ready");
  rw_dir_a: assert property (
    inAcc && extAddrOe |-> readNotWrite != extDataOe)
    else $error("direction wrong");
  fetch_full_a: assert property (
    reqValid && reqReady && req.fetch && !programWidthSelect
    |=> inAcc && !cur_ff.twoHalf && accWidth == WID_32)
    else $error("32-bit fetch split");
  fetch_half_a: assert property (
    inAcc && cur_ff.twoHalf && !readyN && cur_ff.sub == SUB_FIRST
    && cur_ff.space != SPC_IO
    |-> !(memStrobeZero.lane3OrAddr1 && memStrobeOne.lane3OrAddr1)
    ##1 inAcc && cur_ff.sub == SUB_SECOND
    && memStrobeZero.lane3OrAddr1 && memStrobeOne.lane3OrAddr1)
    else $error("second half fetch missing");
  width_reset_a: assert property (
    cur_ff.st == ST_INIT |=> cur_ff.cfg.widthZero
    == ($past(programWidthSelect) ? WID_16 : WID_32)
    && cur_ff.cfg.widthOne == ($past(programWidthSelect) ? WID_16 : WID_32))
    else $error("reset width not loaded");
  hiz_float_a: assert property (
    forceHighImpedance |-> !busReleaseGrantOe && !strobeOe && !extAddrOe
    && !extDataOe && !readNotWriteOe) else $error("float input ignored");
  io_strobe_a: assert property (
    !peripheralIoStrobeN |-> memStrobeZero == STRB_IDLE
    && memStrobeOne == STRB_IDLE)
    else $error("io strobe overlaps memory strobe");
  lane32_a: assert property (
    inAcc && cur_ff.space == SPC_STRB0 && accWidth == WID_32
    |-> memStrobeZero == 4'h0)
    else $error("32-bit lanes not all enabled");

  cover_release_c: cover property (!busReleaseReqN ##[1:8]
    !busReleaseGrantN ##[1:8] busReleaseGrantN);
  cover_wait_c: cover property (inAcc && readyN ##1 inAcc && !readyN);
  cover_fetch16_c: cover property (inAcc && cur_ff.twoHalf ##[1:8]
    respValid);
  cover_io_c: cover property (!peripheralIoStrobeN ##[1:8] respValid);
endmodule
`default_nettype wire

// ---- bench/embi_mem_model.sv ----
/*
  Far-side memory and peripheral model: answers a strobe after a set
  number of wait cycles. Assumes active-low strobes on clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none
module embi_mem_model (
  // Clock, reset and pacing.
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [3:0]             waitCycles,
  // Bus pins seen from outside.
  input  wire logic [23:0]            extAddr,
  input  wire embi_pkg::embi_strobe_s memStrobeZero,
  input  wire embi_pkg::embi_strobe_s memStrobeOne,
  input  wire logic                   peripheralIoStrobeN,
  input  wire logic                   strobeOe,
  input  wire logic                   readNotWrite,
  output logic                        readyN,
  output logic [31:0]                 extDataIn
);
  import embi_pkg::*;
  logic        active;
  logic        addrOne;
  logic [3:0]  waitCnt;
  logic [31:0] lastData;
  // An access is live while the peripheral strobe or a group's lane 0 strobe is low and driven.
  assign active = strobeOe & (~peripheralIoStrobeN | ~memStrobeZero.lane0N
                  | ~memStrobeOne.lane0N);
  assign addrOne = (~memStrobeZero.lane0N & memStrobeZero.lane3OrAddr1)
                 | (~memStrobeOne.lane0N & memStrobeOne.lane3OrAddr1);
  assign readyN = ~(active & (waitCnt >= waitCycles));
  // Outside reads the lines toggle, so a stale value never passes.
  assign extDataIn = (active & readNotWrite)
                   ? ({8'h5a, extAddr} ^ {31'h0, addrOne}) : ~lastData;
  // Wait count restarts at each completing edge.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt  <= 4'h0;
      lastData <= 32'h0;
    end else begin
      lastData <= extDataIn;
      waitCnt  <= (active & readyN) ? waitCnt + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/embi_bus_if_tb.sv ----
/*
  Self-checking bench of the bus interface with the memory model.
  Assumes the hand-over timing: requests held until taken.
*/
`timescale 1ns/100ps
`default_nettype none
module embi_bus_if_tb;
  import embi_pkg::*;
  logic clk_sys, rst_n, reqValid, reqReady, respValid, cfgWrite;
  logic releaseInhibitBit, extAddrOe, extDataOe, readNotWrite;
  logic readNotWriteOe, peripheralIoStrobeN, strobeOe, readyN;
  logic busReleaseReqN, busReleaseGrantN, busReleaseGrantOe;
  logic programWidthSelect, forceHighImpedance;
  logic [31:0]  respData, extDataOut, extDataIn;
  logic [23:0]  extAddr;
  logic [3:0]   waitCycles;
  embi_req_s    req;
  embi_cfg_s    cfgIn, cfgOut;
  embi_strobe_s memStrobeZero, memStrobeOne;
  int           mismatches, check_count;
  embi_bus_if dut (.clk_sys, .rst_n, .reqValid, .reqReady, .req, .respValid,
    .respData, .cfgWrite, .cfgIn, .cfgOut, .releaseInhibitBit, .extAddr,
    .extAddrOe, .extDataOut, .extDataIn, .extDataOe, .readNotWrite,
    .readNotWriteOe, .memStrobeZero, .memStrobeOne, .peripheralIoStrobeN,
    .strobeOe, .readyN, .busReleaseReqN, .busReleaseGrantN,
    .busReleaseGrantOe, .programWidthSelect, .forceHighImpedance);
  embi_mem_model far (.clk_sys, .rst_n, .waitCycles, .extAddr, .memStrobeZero,
    .memStrobeOne, .peripheralIoStrobeN, .strobeOe, .readNotWrite, .readyN,
    .extDataIn);
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Lane pattern per width; lane 2 stays high on 16-bit memory.
  function automatic logic [3:0] lanes(embi_width_e w, logic [1:0] s);
    if (w == WID_8) return {s[0], s[1], 2'b10};
    if (w == WID_16) return {s[1], 3'b100};
    return 4'h0;
  endfunction
  // Word the model returns, narrowed and zero-extended as the width asks.
  function automatic logic [31:0] rd_exp(embi_width_e w, logic [1:0] s,
                                         logic [31:0] a);
    logic [31:0] d;
    d = {8'h5a, a[23:0]};
    if (w == WID_8) return {24'h0, d[7:1], d[0] ^ s[0]};
    if (w == WID_16) return {16'h0, d[15:1], d[0] ^ s[1]};
    return d;
  endfunction
  task automatic pulse_cfg(input embi_width_e w);
    cfgIn = {w, w};
    cfgWrite = 1'b1;
    @(posedge clk_sys);
    #1 cfgWrite = 1'b0;
  endtask
  // One core access; address is the low bits of the data word.
  task automatic access(input logic wr, input logic fe, input logic [1:0] sp,
                        input logic [1:0] sb, input logic [31:0] da,
                        input embi_width_e w);
    int n;
    logic [31:0] exp;
    req = '{wr, fe, embi_space_e'(sp), sb, da[23:0], da};
    reqValid = 1'b1;
    n = 0;
    while (!reqReady && n < 40) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    #1 reqValid = 1'b0;
    check(readNotWrite, !(wr && !fe));
    check(extDataOe, wr && !fe);
    check({extAddrOe, extAddr}, {1'b1, da[23:0]});
    if (wr && !fe) check(extDataOut, da);
    if (sp == 2'h2) check({peripheralIoStrobeN, memStrobeZero}, 5'h0f);
    else if (!fe) check(sp[0] ? memStrobeOne : memStrobeZero,
                        lanes(w, sb));
    while (!respValid && n < 80) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(respValid, 1'b1);
    if (wr && !fe) exp = da;
    else if (fe && programWidthSelect) exp = {da[15:0] ^ 16'h1, da[15:0]};
    else exp = rd_exp(fe ? WID_32 : w, sb, da);
    check(respData, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Watchdog well past the expected run of about 200 cycles.
  initial begin
    #40000;
    mismatches++;
    complete_run();
  end
  // Main sequence: reset, traffic, widths, fetches, release, float.
  initial begin
    rst_n = 1'b0;
    {reqValid, cfgWrite, releaseInhibitBit, forceHighImpedance} = 4'h0;
    {busReleaseReqN, programWidthSelect} = 2'h3;
    req = '0;
    cfgIn = '0;
    waitCycles = 4'h0;
    void'($urandom(53));
    repeat (3) @(posedge clk_sys);
    #1 check({extAddrOe, extDataOe, readNotWriteOe, busReleaseGrantN}, 4'h1);
    rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check(cfgOut, {WID_16, WID_16});
    pulse_cfg(WID_32);
    repeat (24) begin
      waitCycles = 4'($urandom_range(3));
      access(1'($urandom), 1'b0, 2'($urandom_range(2)), 2'h0, $urandom, WID_32);
    end
    for (int w = 0; w < 2; w++) begin
      pulse_cfg(embi_width_e'(w));
      for (int k = 0; k < 8; k++) access(1'b0, 1'b0, 2'(k / 4), 2'(k), $urandom,
                                         embi_width_e'(w));
    end
    pulse_cfg(WID_32);
    for (int p = 0; p < 2; p++) begin
      programWidthSelect = 1'(p);
      access(1'b0, 1'b1, 2'h0, 2'h0, $urandom, WID_32);
    end
    waitCycles = 4'h4;
    fork
      access(1'b0, 1'b0, 2'h1, 2'h0, 32'h00c0ffee, WID_32);
      begin
        repeat (2) @(posedge clk_sys);
        #1 busReleaseReqN = 1'b0;
      end
    join
    repeat (2) @(posedge clk_sys);
    #1 check({busReleaseGrantN, extAddrOe, extDataOe, readNotWriteOe, strobeOe,
              reqReady}, 6'h0);
    releaseInhibitBit = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check({busReleaseGrantN, reqReady}, 2'h3);
    access(1'b1, 1'b0, 2'h0, 2'h0, $urandom, WID_32);
    releaseInhibitBit = 1'b0;
    busReleaseReqN = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check(busReleaseGrantN, 1'b1);
    forceHighImpedance = 1'b1;
    @(posedge clk_sys);
    #1 check({extAddrOe, extDataOe, readNotWriteOe, strobeOe,
              busReleaseGrantOe}, 5'h0);
    forceHighImpedance = 1'b0;
    programWidthSelect = 1'b0;
    rst_n = 1'b0;
    // Under reset the bus lines float but strobes and grant stay driven.
    #1 check({extAddrOe, readNotWriteOe, strobeOe, busReleaseGrantN,
              memStrobeZero}, 8'h3f);
    @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 check(cfgOut, {WID_32, WID_32});
    complete_run();
  end
endmodule
`default_nettype wire
